// ===== hdl/rrhf_top.sv
// Supervision, role and failover logic of an expansion-rack network module.
// Assumes pins are asynchronous to mclk_i; processor-side strobes are not.
`timescale 1ns/1ps

// Operation
// - After reset stay halted until initialised
// - Initialisation gives exactly one role
// - Controller runs chassis, keeps standby synchronised
// - Diagnostics finish before any communication
// - Network-module mode disables first Ethernet port
// - Network type selects address series
// - Switch carries rack address, range checked
// - Run indicator red held, green running
// - Controller indicator follows controller role
// - Standby indicator when ready for failover
// - Low-supply fault on any rail fault
// - Failsafe lock shown locally and backplane
// - Lock within bounded time of fault
// - Watchdog has failover and timeout thresholds
// - Application, watchdog, clock, frame faults trip
// - Trip halts module, lights watchdog indicator
// - Traffic and link indicators follow network
// - Fault indicator flashes reported codes
// - Reset drops controller or standby role
module rrhf_top import rrhf_pkg::*; #(
   parameter int FAIL_CYC = FAILOVER_CYC,
   parameter int TO_CYC = TIMEOUT_CYC,
   parameter int LK_CYC = LOCK_CYC,
   parameter int FL_CYC = FLASH_CYC
) (
   input wire logic mclk_i,                        // Clock
   input wire logic rst_i,                         // Async reset
   input wire logic reset_btn_i,                   // Front reset button pin
   input wire logic peer_ctrl_i,                   // Peer holds controller role
   input wire logic peer_rdy_i,                    // Peer is healthy standby
   input wire logic link_up_i,                     // Network link pin
   input wire logic activity_i,                    // Network traffic pin
   input wire logic [DIP_W-1:0] config_dip_switch_i, // Configuration switch
   input wire logic [RAIL_W-1:0] rail_fault_i,     // Supply rail out of tolerance
   input wire logic diag_done_i,                   // Self test finished
   input wire logic diag_pass_i,                   // Self test passed
   input wire logic init_req_i,                    // Initialise strobe
   input wire logic init_ctrl_i,                   // Initialise as controller
   input wire logic os_running_i,                  // Operating system running
   input wire logic watchdog_indicator_kick_i,                   // Watchdog service strobe
   input wire logic application_program_fault_i,   // Application fault
   input wire logic system_clock_source_fault_i,   // Clock hardware fault
   input wire logic frame_timer_hw_fault_i,        // Frame timer fault
   input wire logic code_valid_i,                  // Fault code to report
   input wire logic [DIGIT_W-1:0] code_a_i,        // Fault code first digit
   input wire logic [DIGIT_W-1:0] code_b_i,        // Fault code second digit
   output logic running_o,                         // Module in operation
   output logic comm_en_o,                         // Communication allowed
   output logic backplane_controller_role_o,       // Controller role held
   output logic standby_o,                         // Standby role held
   output logic sync_en_o,                         // Keep standby synchronised
   output logic first_general_eth_port_en_o,       // First Ethernet port enable
   output logic alt_addr_series_o,                 // Alternate address series
   output logic [RACK_W-1:0] rack_addr_o,          // Rack address
   output logic rack_addr_ok_o,                    // Rack address in range
   output logic run_red_o,                         // Run indicator red
   output logic run_green_o,                       // Run indicator green
   output logic ctrl_led_o,                        // Controller indicator
   output logic standby_led_o,                     // Standby indicator
   output logic low_supply_fault_o,                // Low-supply indicator
   output logic io_failsafe_lock_o,                // Lock indicator, local
   output logic io_failsafe_lock_bp_o,             // Lock drive, backplane
   output logic watchdog_indicator_o,              // Watchdog indicator
   output logic traffic_led_o,                     // Traffic indicator
   output logic link_led_o,                        // Link indicator
   output logic fault_led_o                        // Fault indicator
);
   typedef struct packed {
      logic [PIN_W-1:0] q1;
      logic [PIN_W-1:0] q2;
      rrhf_state_t st;
      logic run;
      logic ctrl;
      logic stby;
      logic [CNT_W-1:0] lcnt;
      logic lock;
      logic wd_led;
      logic lowv;
      logic eth1;
      logic alt;
      logic [RACK_W-1:0] rack;
      logic rack_ok;
      logic red;
      logic green;
      logic trx;
      logic link;
   } rrhf_st_t;
   rrhf_st_t r, next_r;

   logic [PIN_W-1:0] pins;
   logic wd_fo, wd_to, flash_led, fault_led;

   assign pins = {rail_fault_i, config_dip_switch_i, activity_i, link_up_i,
                  peer_rdy_i, peer_ctrl_i, reset_btn_i};

   function automatic logic rack_in_range(input logic [DIP_W-1:0] dip);
      logic [RACK_W-1:0] a;
      a = dip[DIP_RACK_LSB +: RACK_W];
      rack_in_range = (a != '0) &&
                      (a <= (dip[DIP_TMR_BIT] ? RACK_MAX_TMR : RACK_MAX_EXT));
   endfunction

   rrhf_watchdog_indicator #(
      .FAIL_CYC(FAIL_CYC),
      .TO_CYC(TO_CYC)
   ) u_watchdog_indicator (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .en_i(r.st == ST_RUN),
      .kick_i(watchdog_indicator_kick_i),
      .failover_o(wd_fo),
      .timeout_o(wd_to)
   );

   rrhf_flash #(
      .UNIT_CYC(FL_CYC)
   ) u_flash (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .valid_i(code_valid_i),
      .digit_a_i(code_a_i),
      .digit_b_i(code_b_i),
      .led_o(flash_led)
   );

   ////////////////////////////////////////////////////////////////////////////
   logic btn, pctrl, prdy, trip, local_fault, accept;
   logic [DIP_W-1:0] dip;

   always_comb begin
      btn = r.q2[PIN_BTN];
      pctrl = r.q2[PIN_PEER_CTRL];
      prdy = r.q2[PIN_PEER_RDY];
      dip = r.q2[PIN_DIP_LSB +: DIP_W];
      trip = wd_to | application_program_fault_i | system_clock_source_fault_i |
             frame_timer_hw_fault_i;
      local_fault = trip | wd_fo | btn | (|r.q2[PIN_RAIL_LSB +: RAIL_W]);
      accept = (r.st == ST_HALT) && init_req_i && !btn;
      next_r = r;
      // First stage feeds only the second
      next_r.q1 = pins;
      next_r.q2 = r.q1;
      case (r.st)
         ST_DIAG: begin
            if (diag_done_i && diag_pass_i) begin
               next_r.st = ST_HALT;
            end
         end
         ST_HALT: begin
            if (init_req_i && !btn) begin
               next_r.st = ST_RUN;
               // Refuse the role while the peer still shows it
               next_r.ctrl = init_ctrl_i && !pctrl;
               next_r.stby = !(init_ctrl_i && !pctrl);
               next_r.lock = 1'b0;
               next_r.wd_led = 1'b0;
            end
         end
         ST_RUN: begin
            if (r.stby && !pctrl && prdy == 1'b0 && !local_fault) begin
               // Peer released the role first, so no overlap
               next_r.ctrl = 1'b1;
               next_r.stby = 1'b0;
            end
            if (wd_fo) begin
               // Short threshold hands control to the peer
               next_r.ctrl = 1'b0;
               next_r.stby = 1'b0;
               next_r.wd_led = 1'b1;
            end
            if (trip) begin
               next_r.st = ST_TRIP;
               next_r.ctrl = 1'b0;
               next_r.stby = 1'b0;
               next_r.wd_led = 1'b1;
            end
         end
         ST_TRIP: begin
            if (init_req_i && !btn) begin
               next_r.st = ST_HALT;
            end
         end
         default: next_r.st = ST_DIAG;
      endcase
      if (btn) begin
         next_r.st = (r.st == ST_DIAG) ? ST_DIAG : ST_HALT;
         next_r.ctrl = 1'b0;
         next_r.stby = 1'b0;
         next_r.wd_led = 1'b1;
      end
      // No controller in the rack: count toward the lock deadline
      // A fresh init restarts the deadline, as it also clears the lock
      if (r.ctrl || pctrl || accept) begin
         next_r.lcnt = '0;
      end else if (r.st != ST_DIAG && r.lcnt != CNT_W'(LK_CYC - 1)) begin
         next_r.lcnt = r.lcnt + 1'b1;
      end
      if ((r.ctrl && local_fault && !prdy) ||
          (r.lcnt == CNT_W'(LK_CYC - 2) && !accept)) begin
         next_r.lock = 1'b1;
      end
      next_r.lowv = |r.q2[PIN_RAIL_LSB +: RAIL_W];
      next_r.eth1 = !dip[DIP_MODE_BIT];
      next_r.alt = dip[DIP_NET_BIT];
      next_r.rack = dip[DIP_RACK_LSB +: RACK_W];
      next_r.rack_ok = rack_in_range(dip);
      next_r.red = btn;
      next_r.green = !btn && os_running_i;
      next_r.trx = r.q2[PIN_ACT];
      next_r.link = r.q2[PIN_LINK];
      next_r.run = (next_r.st == ST_RUN);
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '0;
         r.st <= ST_DIAG;
         r.eth1 <= 1'b1;
         r.rack <= RACK_DEFAULT;
      end else begin
         r <= next_r;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         fault_led <= 1'b0;
      end else begin
         fault_led <= flash_led;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic stby_rdy, sync_q;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         stby_rdy <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         stby_rdy <= next_r.stby && next_r.st == ST_RUN && !local_fault;
         sync_q <= next_r.ctrl && next_r.st == ST_RUN && prdy;
      end
   end

   assign running_o = r.run;
   assign comm_en_o = r.run;
   assign backplane_controller_role_o = r.ctrl;
   assign standby_o = r.stby;
   assign sync_en_o = sync_q;
   assign first_general_eth_port_en_o = r.eth1;
   assign alt_addr_series_o = r.alt;
   assign rack_addr_o = r.rack;
   assign rack_addr_ok_o = r.rack_ok;
   assign run_red_o = r.red;
   assign run_green_o = r.green;
   assign ctrl_led_o = r.ctrl;
   assign standby_led_o = stby_rdy;
   assign low_supply_fault_o = r.lowv;
   assign io_failsafe_lock_o = r.lock;
   assign io_failsafe_lock_bp_o = r.lock;
   assign watchdog_indicator_o = r.wd_led;
   assign traffic_led_o = r.trx;
   assign link_led_o = r.link;
   assign fault_led_o = fault_led;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   a_no_self_run: assert property (
      !running_o && !init_req_i |=> !running_o)
      else $error("module entered operation without initialisation");
   a_single_role: assert property (
      !(backplane_controller_role_o && standby_o))
      else $error("both roles held");
   a_sync_ctrl: assert property (
      sync_en_o |-> backplane_controller_role_o && running_o)
      else $error("sync without controller role");
   a_no_diag_comm: assert property (
      r.st == ST_DIAG |-> !comm_en_o)
      else $error("communication during diagnostics");
   a_eth_disable: assert property (
      dip[DIP_MODE_BIT] |=> !first_general_eth_port_en_o)
      else $error("first port enabled in network mode");
   a_run_red: assert property (
      btn |=> run_red_o && !run_green_o)
      else $error("run indicator not red while held");
   a_low_supply: assert property (
      $rose(|r.q2[PIN_RAIL_LSB +: RAIL_W]) |=> low_supply_fault_o)
      else $error("rail fault not flagged");
   a_lock_bound: assert property (
      r.lcnt == CNT_W'(LK_CYC - 1) |-> io_failsafe_lock_o && io_failsafe_lock_bp_o)
      else $error("lock late");
   a_trip_halt: assert property (
      running_o && wd_to |=> !running_o && watchdog_indicator_o [*2])
      else $error("trip did not halt");
   a_reset_drop: assert property (
      btn |=> !backplane_controller_role_o && !standby_o)
      else $error("role kept through reset");
   a_one_ctrl: assert property (
      $rose(backplane_controller_role_o) |-> !$past(pctrl))
      else $error("role taken while peer held it");
   a_no_take: assert property (
      pctrl && !backplane_controller_role_o |=> !backplane_controller_role_o)
      else $error("role taken while peer showed it");
   a_fault_lock: assert property (
      backplane_controller_role_o && local_fault && !prdy |=> io_failsafe_lock_o)
      else $error("lock missing after controller fault");
   a_trip_stop: assert property (
      running_o && trip |=> !running_o)
      else $error("health fault did not stop the module");
   a_wd_lamp: assert property (
      running_o ##1 !running_o |-> watchdog_indicator_o)
      else $error("stop without watchdog indicator");
   a_wd_failover: assert property (
      running_o && wd_fo |=> !backplane_controller_role_o)
      else $error("role kept after failover event");
   a_rack_check: assert property (
      rack_addr_ok_o |-> rack_addr_o != '0)
      else $error("rack zero flagged valid");
   a_addr_series: assert property (
      dip[DIP_NET_BIT] |=> alt_addr_series_o)
      else $error("alternate series not selected");
   a_link_lamp: assert property (
      r.q2[PIN_LINK] |=> link_led_o)
      else $error("link indicator off");
   a_standby_lamp: assert property (
      standby_led_o |-> standby_o && running_o)
      else $error("standby indicator without standby role");

   c_take_over: cover property (standby_o ##[1:1000] backplane_controller_role_o);
   c_lock: cover property ($rose(io_failsafe_lock_o));
   c_trip: cover property (running_o ##1 watchdog_indicator_o && !running_o);
   c_standby: cover property (standby_led_o);
   c_low_supply: cover property ($rose(low_supply_fault_o));
endmodule

// ===== hdl/rrhf_pkg.sv
// Constants and types of the rack health and failover block.
// Assumes one 250 MHz clock and a single-module-per-file layout.
package rrhf_pkg;
   localparam int CLK_NS = 4;
   localparam int NS_PER_MS = 1000000;
   localparam int FAILOVER_MS = 1;
   localparam int TIMEOUT_MS = 18;
   localparam int LOCK_MS = 55;
   localparam int FLASH_MS = 250;
   localparam int FAILOVER_CYC = FAILOVER_MS * NS_PER_MS / CLK_NS;
   localparam int TIMEOUT_CYC = TIMEOUT_MS * NS_PER_MS / CLK_NS;
   localparam int LOCK_CYC = LOCK_MS * NS_PER_MS / CLK_NS;
   localparam int FLASH_CYC = FLASH_MS * NS_PER_MS / CLK_NS;
   localparam int CNT_W = 26;
   // Synchronised pin vector layout
   localparam int PIN_BTN = 0;
   localparam int PIN_PEER_CTRL = 1;
   localparam int PIN_PEER_RDY = 2;
   localparam int PIN_LINK = 3;
   localparam int PIN_ACT = 4;
   localparam int PIN_DIP_LSB = 5;
   localparam int DIP_W = 6;
   localparam int PIN_RAIL_LSB = 11;
   localparam int RAIL_W = 8;
   localparam int PIN_W = 19;
   // Configuration switch fields
   localparam int DIP_MODE_BIT = 0;
   localparam int DIP_NET_BIT = 1;
   localparam int DIP_TMR_BIT = 2;
   localparam int DIP_RACK_LSB = 3;
   localparam int RACK_W = 3;
   localparam logic [RACK_W-1:0] RACK_DEFAULT = 3'h1;
   localparam logic [RACK_W-1:0] RACK_MAX_EXT = 3'h7;
   localparam logic [RACK_W-1:0] RACK_MAX_TMR = 3'h3;
   localparam int DIGIT_W = 4;
   typedef enum logic [1:0] {ST_DIAG, ST_HALT, ST_RUN, ST_TRIP} rrhf_state_t;
   typedef enum logic [1:0] {FL_IDLE, FL_ON, FL_OFF, FL_GAP} rrhf_flash_t;
endpackage

// ===== hdl/rrhf_watchdog_indicator.sv
// Processor watchdog with a short failover and a long timeout threshold.
// Assumes kick_i and en_i come from logic on mclk_i.
`timescale 1ns/1ps
module rrhf_watchdog_indicator import rrhf_pkg::*; #(
   parameter int FAIL_CYC = FAILOVER_CYC,
   parameter int TO_CYC = TIMEOUT_CYC
) (
   input wire logic mclk_i,    // Clock
   input wire logic rst_i,     // Async reset
   input wire logic en_i,      // Watching enabled
   input wire logic kick_i,    // Service pulse
   output logic failover_o,    // Short threshold pulse
   output logic timeout_o      // Long threshold pulse
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic fo;
      logic to;
   } rrhf_watchdog_indicator_st_t;
   rrhf_watchdog_indicator_st_t r, next_r;

   always_comb begin
      next_r = r;
      next_r.fo = 1'b0;
      next_r.to = 1'b0;
      if (!en_i || kick_i) begin
         next_r.cnt = '0;
      end else if (r.cnt != CNT_W'(TO_CYC)) begin
         next_r.cnt = r.cnt + 1'b1;
         next_r.fo = (r.cnt == CNT_W'(FAIL_CYC - 1));
         next_r.to = (r.cnt == CNT_W'(TO_CYC - 1));
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign failover_o = r.fo;
   assign timeout_o = r.to;
endmodule

// ===== hdl/rrhf_flash.sv
// Fault code flasher: blinks digit A, pauses, blinks digit B, pauses.
// Assumes code inputs come from logic on mclk_i and hold while valid.
`timescale 1ns/1ps
module rrhf_flash import rrhf_pkg::*; #(
   parameter int UNIT_CYC = FLASH_CYC
) (
   input wire logic mclk_i,                 // Clock
   input wire logic rst_i,                  // Async reset
   input wire logic valid_i,                // Code to report
   input wire logic [DIGIT_W-1:0] digit_a_i, // First digit
   input wire logic [DIGIT_W-1:0] digit_b_i, // Second digit
   output logic led_o                       // Fault indicator
);
   typedef struct packed {
      rrhf_flash_t ph;
      logic sel;
      logic [DIGIT_W-1:0] n;
      logic [CNT_W-1:0] tick;
      logic led;
   } rrhf_flash_st_t;
   rrhf_flash_st_t r, next_r;

   always_comb begin
      next_r = r;
      next_r.tick = r.tick + 1'b1;
      if (r.tick == CNT_W'(UNIT_CYC - 1)) begin
         next_r.tick = '0;
         case (r.ph)
            FL_IDLE: begin
               if (valid_i) begin
                  next_r.n = digit_a_i;
                  next_r.sel = 1'b0;
                  next_r.ph = FL_ON;
               end
            end
            FL_ON: next_r.ph = FL_OFF;
            FL_OFF: begin
               if (r.n > 4'h1) begin
                  next_r.n = r.n - 1'b1;
                  next_r.ph = FL_ON;
               end else begin
                  next_r.ph = FL_GAP;
               end
            end
            FL_GAP: begin
               if (!r.sel && valid_i) begin
                  next_r.n = digit_b_i;
                  next_r.sel = 1'b1;
                  next_r.ph = FL_ON;
               end else begin
                  next_r.ph = FL_IDLE;
               end
            end
            default: next_r.ph = FL_IDLE;
         endcase
      end
      next_r.led = (next_r.ph == FL_ON);
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign led_o = r.led;
endmodule

// ===== verification/rrhf_peer_model.sv
// Behavioural model of the peer redundant module beside the block.
// Assumes the bench steers its health and wish for the controller role.
`timescale 1ns/1ps
module rrhf_peer_model import rrhf_pkg::*; #(
   parameter int TAKE_DLY = 4
) (
   input wire logic mclk_i,     // Clock
   input wire logic rst_i,      // Async reset
   input wire logic healthy_i,  // Peer fit to serve
   input wire logic want_ctrl_i, // Peer wants the controller role
   input wire logic dut_ctrl_i, // Block holds the controller role
   output logic peer_ctrl_o,    // Peer holds the controller role
   output logic peer_rdy_o      // Peer is a ready standby
);
   logic [7:0] free_cnt;
   ////////////////////////////////////////////////////////////////////////////
   // Waits a few cycles after the block lets go, so roles never overlap
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         peer_ctrl_o <= 1'b0;
         free_cnt <= 8'h00;
      end else begin
         free_cnt <= dut_ctrl_i ? 8'h00 : ((free_cnt == 8'hFF) ? free_cnt : free_cnt + 8'h01);
         if (!healthy_i || dut_ctrl_i) begin
            peer_ctrl_o <= 1'b0;
         end else if (want_ctrl_i && free_cnt >= 8'(TAKE_DLY)) begin
            peer_ctrl_o <= 1'b1;
         end
      end
   end
   assign peer_rdy_o = healthy_i && !peer_ctrl_o;
endmodule

// ===== verification/tb_top.sv
// Self-checking bench of the rack health and failover block.
// Assumes shortened counts and a behavioural peer module.
`timescale 1ns/1ps
module tb_top import rrhf_pkg::*;;
   localparam int FC = 20;
   localparam int TC = 60;
   localparam int LC = 100;
   localparam int UC = 4;
   logic mclk_i = 1'b0, rst_i = 1'b1, btn = 1'b0, link = 1'b0, act = 1'b0;
   logic diag_done = 1'b0, diag_pass = 1'b0, init_req = 1'b0, init_ctrl = 1'b0;
   logic os_run = 1'b0, kick = 1'b0, f_app = 1'b0, f_clk = 1'b0, f_frm = 1'b0;
   logic valid = 1'b0, kick_en = 1'b1, healthy = 1'b1, want = 1'b0;
   logic [DIP_W-1:0] dip = 6'h09;
   logic [RAIL_W-1:0] rail = 8'h00;
   logic [DIGIT_W-1:0] ca = 4'h0, cb = 4'h0;
   logic peer_ctrl, peer_rdy, running, comm_en, role, stby, sync_en, eth_en, alt;
   logic ok, red, green, ctrl_led, stby_led, lowv, lock, lock_bp, wd, traf, lnk, fled;
   logic [RACK_W-1:0] rack;
   logic [31:0] seed = 32'h4661F79E;
   logic [7:0] kcnt = 8'h00;
   int n_errors = 0;
   int samples_checked = 0;
   int k;
   always #2 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      kcnt <= kcnt + 8'h01;
      kick <= kick_en && kcnt[2:0] == 3'h0;
   end
   rrhf_peer_model rrhf_peer_model_inst (.mclk_i(mclk_i), .rst_i(rst_i), .healthy_i(healthy),
      .want_ctrl_i(want), .dut_ctrl_i(role), .peer_ctrl_o(peer_ctrl), .peer_rdy_o(peer_rdy));
   rrhf_top #(.FAIL_CYC(FC), .TO_CYC(TC), .LK_CYC(LC), .FL_CYC(UC)) rrhf_top_inst (
      .mclk_i(mclk_i), .rst_i(rst_i), .reset_btn_i(btn), .peer_ctrl_i(peer_ctrl),
      .peer_rdy_i(peer_rdy), .link_up_i(link), .activity_i(act), .config_dip_switch_i(dip),
      .rail_fault_i(rail), .diag_done_i(diag_done), .diag_pass_i(diag_pass),
      .init_req_i(init_req), .init_ctrl_i(init_ctrl), .os_running_i(os_run),
      .watchdog_indicator_kick_i(kick), .application_program_fault_i(f_app),
      .system_clock_source_fault_i(f_clk), .frame_timer_hw_fault_i(f_frm),
      .code_valid_i(valid), .code_a_i(ca), .code_b_i(cb), .running_o(running),
      .comm_en_o(comm_en), .backplane_controller_role_o(role), .standby_o(stby),
      .sync_en_o(sync_en), .first_general_eth_port_en_o(eth_en), .alt_addr_series_o(alt),
      .rack_addr_o(rack), .rack_addr_ok_o(ok), .run_red_o(red), .run_green_o(green),
      .ctrl_led_o(ctrl_led), .standby_led_o(stby_led), .low_supply_fault_o(lowv),
      .io_failsafe_lock_o(lock), .io_failsafe_lock_bp_o(lock_bp), .watchdog_indicator_o(wd),
      .traffic_led_o(traf), .link_led_o(lnk), .fault_led_o(fled));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // Zero is no rack; the upper bound depends on the system kind
   function automatic logic rack_ok(input logic [DIP_W-1:0] d);
      return d[5:3] != 3'h0 && d[5:3] <= (d[DIP_TMR_BIT] ? RACK_MAX_TMR : RACK_MAX_EXT);
   endfunction
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("errors %0d, comparisons %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge mclk_i);
   endtask
   task automatic bound(input int lim, input string m);
      if (k >= lim) begin
         check(8'h00, 8'h01, m);
         give_verdict();
      end
   endtask
   // A tripped module needs a second request to run
   task automatic do_init(input logic c);
      repeat (2) begin
         if (running !== 1'b1) begin
            @(posedge mclk_i);
            init_req <= 1'b1;
            init_ctrl <= c;
            @(posedge mclk_i);
            init_req <= 1'b0;
            tick(2);
         end
      end
   endtask
   // Two controllers must never coexist
   always @(negedge mclk_i) begin
      if (!rst_i && role === 1'b1 && peer_ctrl === 1'b1) begin
         check(8'h01, 8'h00, "two controllers");
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      tick(2);
      check(eth_en, 8'h01, "eth port in reset");
      check(rack, RACK_DEFAULT, "rack in reset");
      @(posedge mclk_i);
      rst_i <= 1'b0;
      tick(4);
      do_init(1'b1);
      check({running, comm_en}, 8'h00, "init during diagnostics");
      @(posedge mclk_i);
      diag_done <= 1'b1;
      diag_pass <= 1'b1;
      for (k = 0; k < LC + 8 && lock !== 1'b1; k++) tick(1);
      bound(LC + 8, "lock deadline");
      check(lock_bp, 8'h01, "backplane lock");
      check(running, 8'h00, "no self start");
      repeat (16) begin
         seed = xs(seed);
         @(posedge mclk_i);
         dip <= seed[5:0];
         rail <= seed[6] ? seed[15:8] : 8'h00;
         link <= seed[16];
         act <= seed[17];
         tick(4);
         check(eth_en, !dip[DIP_MODE_BIT], "eth port enable");
         check(alt, dip[DIP_NET_BIT], "address series");
         check(rack, dip[5:3], "rack address");
         check(ok, rack_ok(dip), "rack range");
         check(lowv, |rail, "low supply");
         check({traf, lnk}, {act, link}, "network leds");
      end
      @(posedge mclk_i);
      dip <= 6'h09;
      rail <= 8'h00;
      tick(4);
      do_init(1'b1);
      check({running, comm_en, role, ctrl_led, stby}, 8'h1E, "controller init");
      check(lock, 8'h00, "lock cleared by init");
      tick(3);
      check(sync_en, 8'h01, "standby sync");
      @(posedge mclk_i);
      os_run <= 1'b1;
      healthy <= 1'b0;
      tick(4);
      check({red, green}, 8'h01, "run green");
      @(posedge mclk_i);
      btn <= 1'b1;
      tick(5);
      check({red, green, running, role, wd}, 8'h11, "button held");
      check({lock, lock_bp}, 8'h03, "lock on controller reset");
      @(posedge mclk_i);
      btn <= 1'b0;
      tick(4);
      for (int f = 0; f < 3; f++) begin
         do_init(1'b1);
         check(role, 8'h01, "role before fault");
         @(posedge mclk_i);
         {f_app, f_clk, f_frm} <= 3'(3'h4 >> f);
         tick(3);
         check({running, role, wd}, 8'h01, "health fault trip");
         @(posedge mclk_i);
         {f_app, f_clk, f_frm} <= 3'h0;
      end
      do_init(1'b1);
      tick(3 * FC);
      check({role, wd}, 8'h02, "kicked watchdog");
      @(posedge mclk_i);
      kick_en <= 1'b0;
      tick(FC - 8);
      check({role, wd}, 8'h02, "before failover event");
      tick(12);
      check({running, role, stby, wd}, 8'h09, "failover event");
      @(posedge mclk_i);
      healthy <= 1'b1;
      want <= 1'b1;
      tick(TC);
      check({running, wd}, 8'h01, "timeout event");
      @(posedge mclk_i);
      kick_en <= 1'b1;
      do_init(1'b1);
      check({running, role, stby}, 8'h05, "standby behind peer");
      tick(3);
      check(stby_led, 8'h01, "standby ready");
      @(posedge mclk_i);
      healthy <= 1'b0;
      for (k = 0; k < 12 && role !== 1'b1; k++) tick(1);
      bound(12, "failover take");
      check({stby, ctrl_led, stby_led}, 8'h02, "after take");
      for (int p = 0; p < 2; p++) begin
         int u;
         int rises;
         seed = xs(seed);
         @(posedge mclk_i);
         ca <= 4'h1 + 4'(seed[1:0]);
         cb <= 4'h1 + 4'(seed[3:2]);
         valid <= 1'b1;
         tick(1);
         u = (2 * (ca + cb) + 3) * UC;
         rises = 0;
         tick(u + 4);
         repeat (u) begin
            logic prev;
            prev = fled;
            tick(1);
            if (!prev && fled === 1'b1) rises++;
         end
         check(8'(rises), 8'(ca + cb), "flash pulses");
         @(posedge mclk_i);
         valid <= 1'b0;
         tick(2 * u);
      end
      give_verdict();
   end
endmodule
